// ==== cad_counter_array_ctrl.v ====
// Function
// - control bit 6 of each block runs that block's counter; software sets and clears it
// - bit 5 of each block control enables that block's overflow interrupt
// - bit 4 halts that block's counter while the cpu is idle
// - bit 2 picks ten-bit (1) or sixteen-bit (0) wide pwm; bit 3 reserved
// - clock select 00 prescaler, 01 timer 0 overflow, 10 external pin
// - status resets to zero; overflow bits 7 and 3, module flags around them
// - hardware sets overflow flag on rollover; interrupts only when enabled
// - overflow flag set by hardware or write of 1; cleared only by software
// - module flag set on match or capture, held until software clears it
// - all eight event sources ored into one interrupt request
// - six module mode registers reset to zero with the listed fields
// - mode bit 7 lets the module flag request an interrupt
// - mode bit 6 enables the comparator; otherwise matches are ignored
// - bit 5 captures rising edges, bit 4 falling, both give either edge
// - mode bit 3 lets a comparator match set the module flag
// - mode bit 2 inverts the module pin on every comparator match while the pwm code is 00
// - pwm code 01, 10, 11 select pwm kinds; nonzero makes pin a pwm output
// - zero mode is idle; comp plus match is timer; plus toggle is toggle
// - fixed 8-bit pwm goes high at low byte >= duty while mode bit 6 is set; reload on overflow
`timescale 1ns/1ps
`include "cad_defines.vh"

module cad_counter_array_ctrl
#(
    parameter NMOD = 6
)
(
    // clock and reset
    input  wire              CLK,
    input  wire              NRST,
    // special function register port
    input  wire [7:0]        SFR_ADDR,
    input  wire [7:0]        SFR_WDATA,
    input  wire              SFR_WR,
    input  wire              SFR_RD,
    output reg  [7:0]        SFR_RDATA,
    // cpu state
    input  wire              CPU_IDLE,
    // counter datapath
    input  wire [1:0]        CNT_OVF,
    input  wire [1:0]        CNT_LO_OVF,
    input  wire [15:0]       CNT_LO,
    output reg  [1:0]        CNT_RUN,
    output reg  [3:0]        CNT_CLK_SEL,
    output reg  [1:0]        CNT_TEN_BIT,
    // compare datapath
    input  wire [NMOD-1:0]   CMP_MATCH,
    input  wire [NMOD*8-1:0] DUTY_HI,
    input  wire [NMOD-1:0]   PWM_WIDE_LVL,
    output reg  [NMOD*2-1:0] PWM_SEL,
    output reg  [NMOD-1:0]   CAPTURE,
    // module pins
    input  wire [NMOD-1:0]   MODULE_PIN_IN,
    output reg  [NMOD-1:0]   MODULE_PIN_OUT,
    output reg  [NMOD-1:0]   MODULE_PIN_OE,
    // interrupt to cpu
    output reg               IRQ
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function pwm_on;
        input [7:0] md;
        begin
            pwm_on = (md[`CAD_MD_PWM_HI:`CAD_MD_PWM_LO] != `CAD_PWM_OFF);
        end
    endfunction

    function [7:0] mode_addr;
        input integer idx;
        begin
            case (idx)
                0:       mode_addr = `CAD_ADDR_MODE0;
                1:       mode_addr = `CAD_ADDR_MODE1;
                2:       mode_addr = `CAD_ADDR_MODE2;
                3:       mode_addr = `CAD_ADDR_MODE3;
                4:       mode_addr = `CAD_ADDR_MODE4;
                default: mode_addr = `CAD_ADDR_MODE5;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    reg  [7:0]        ctrl0_ff;
    reg  [7:0]        ctrl1_ff;
    reg  [7:0]        status_ff;
    reg  [7:0]        nxt_status;
    reg  [7:0]        nxt_rdata;
    reg  [7:0]        irq_src;
    wire [NMOD*8-1:0] mode_flat;
    wire [NMOD-1:0]   mod_event;
    wire [NMOD-1:0]   pin_lvl;
    wire [NMOD-1:0]   pin_oe;
    wire [NMOD-1:0]   cap_evt;
    wire              wr_ctrl0;
    wire              wr_ctrl1;
    wire              wr_status;
    wire              halt;
    integer           k;
    integer           n;

    assign wr_ctrl0  = SFR_WR && (SFR_ADDR == `CAD_ADDR_CTRL0);
    assign wr_ctrl1  = SFR_WR && (SFR_ADDR == `CAD_ADDR_CTRL1);
    assign wr_status = SFR_WR && (SFR_ADDR == `CAD_ADDR_STATUS);

    // ----------------------------------------------------------------
    // block control registers
    // ----------------------------------------------------------------
    always @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ctrl0_ff <= `CAD_RST_CTRL;
            ctrl1_ff <= `CAD_RST_CTRL;
        end
        else
        begin
            if (wr_ctrl0)
                ctrl0_ff <= SFR_WDATA & `CAD_CTL0_MASK;
            if (wr_ctrl1)
                ctrl1_ff <= SFR_WDATA & `CAD_CTL1_MASK;
        end
    end

    // ----------------------------------------------------------------
    // counter steering
    // ----------------------------------------------------------------
    // cpu idle runs on the core clock, so it needs no synchroniser
    assign halt = CPU_IDLE;

    always @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            CNT_RUN     <= 2'h0;
            CNT_CLK_SEL <= 4'h0;
            CNT_TEN_BIT <= 2'h0;
        end
        else
        begin
            // run bit, or the common start bit, gated by idle halt
            CNT_RUN[0] <= (ctrl0_ff[`CAD_CTL_RUN] | ctrl0_ff[`CAD_CTL_ALL])
                        & ~(halt & ctrl0_ff[`CAD_CTL_IDLE]);
            CNT_RUN[1] <= (ctrl1_ff[`CAD_CTL_RUN] | ctrl0_ff[`CAD_CTL_ALL])
                        & ~(halt & ctrl1_ff[`CAD_CTL_IDLE]);
            CNT_CLK_SEL <=
                {ctrl1_ff[`CAD_CTL_CLK_HI:`CAD_CTL_CLK_LO],
                 ctrl0_ff[`CAD_CTL_CLK_HI:`CAD_CTL_CLK_LO]};
            CNT_TEN_BIT <= {ctrl1_ff[`CAD_CTL_TENBIT],
                            ctrl0_ff[`CAD_CTL_TENBIT]};
        end
    end

    // ----------------------------------------------------------------
    // per-module logic
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < NMOD; i = i + 1)
        begin : g_mod
            reg  [7:0] mode_ff;
            reg  [2:0] sync_ff;
            reg        tgl_ff;
            reg  [7:0] duty_ff;
            wire       match;
            wire       blk;
            wire       fix8_hi;

            assign mode_flat[i*8 +: 8] = mode_ff;
            assign blk = (i >= 3);

            // register write; reset to zero
            always @(posedge CLK or negedge NRST)
            begin
                if (!NRST)
                    mode_ff <= `CAD_RST_MODE;
                else if (SFR_WR && (SFR_ADDR == mode_addr(i)))
                    mode_ff <= SFR_WDATA;
            end

            // two-stage synchroniser then a history stage
            always @(posedge CLK or negedge NRST)
            begin
                if (!NRST)
                    sync_ff <= 3'h0;
                else
                    sync_ff <= {sync_ff[1:0], MODULE_PIN_IN[i]};
            end

            assign cap_evt[i] =
                (mode_ff[`CAD_MD_CAPR] & sync_ff[1] & ~sync_ff[2]) |
                (mode_ff[`CAD_MD_CAPF] & ~sync_ff[1] & sync_ff[2]);

            // matches only count with the comparator enabled
            assign match = CMP_MATCH[i] & mode_ff[`CAD_MD_COMP];

            assign mod_event[i] = cap_evt[i] |
                                  (match & mode_ff[`CAD_MD_MATCH]);

            // toggle output state
            always @(posedge CLK or negedge NRST)
            begin
                if (!NRST)
                    tgl_ff <= 1'b0;
                else if (match & mode_ff[`CAD_MD_TOGGLE])
                    tgl_ff <= ~tgl_ff;
            end

            // staged duty reloaded at the low byte overflow
            always @(posedge CLK or negedge NRST)
            begin
                if (!NRST)
                    duty_ff <= 8'h00;
                else if (CNT_LO_OVF[blk])
                    duty_ff <= DUTY_HI[i*8 +: 8];
            end

            // low byte at or past the staged duty drives the pin high
            assign fix8_hi = (CNT_LO[blk*8 +: 8] >= duty_ff);

            assign pin_lvl[i] =
                (mode_ff[`CAD_MD_PWM_HI:`CAD_MD_PWM_LO] == `CAD_PWM_FIX8) ?
                    (fix8_hi & mode_ff[`CAD_MD_COMP]) :
                pwm_on(mode_ff) ? PWM_WIDE_LVL[i] : tgl_ff;

            assign pin_oe[i] = pwm_on(mode_ff) |
                               mode_ff[`CAD_MD_TOGGLE];
        end
    endgenerate

    // ----------------------------------------------------------------
    // pin, capture and mode outputs
    // ----------------------------------------------------------------
    always @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            MODULE_PIN_OUT <= {NMOD{1'b0}};
            MODULE_PIN_OE  <= {NMOD{1'b0}};
            CAPTURE        <= {NMOD{1'b0}};
            PWM_SEL        <= {NMOD*2{1'b0}};
        end
        else
        begin
            MODULE_PIN_OUT <= pin_lvl;
            MODULE_PIN_OE  <= pin_oe;
            CAPTURE        <= cap_evt;
            for (n = 0; n < NMOD; n = n + 1)
                PWM_SEL[n*2 +: 2] <= mode_flat[n*8 +: 2];
        end
    end

    // ----------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------
    always @*
    begin
        // software writes first, hardware sets win over clears
        nxt_status = wr_status ? SFR_WDATA : status_ff;
        nxt_status[`CAD_ST_FIRST_BLOCK_OVERFLOW_FLAG] = nxt_status[`CAD_ST_FIRST_BLOCK_OVERFLOW_FLAG] | CNT_OVF[0];
        nxt_status[`CAD_ST_SECOND_BLOCK_OVERFLOW_FLAG] = nxt_status[`CAD_ST_SECOND_BLOCK_OVERFLOW_FLAG] |
                                   CNT_OVF[1];
        // capture and match events share one flag per module
        nxt_status[2:0] = nxt_status[2:0] | mod_event[2:0];
        nxt_status[6:4] = nxt_status[6:4] | mod_event[5:3];
    end

    always @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            status_ff <= `CAD_RST_STATUS;
        else
            status_ff <= nxt_status;
    end

    // ----------------------------------------------------------------
    // interrupt request
    // ----------------------------------------------------------------
    always @*
    begin
        irq_src = 8'h00;
        irq_src[`CAD_ST_FIRST_BLOCK_OVERFLOW_FLAG] = status_ff[`CAD_ST_FIRST_BLOCK_OVERFLOW_FLAG] &
                                ctrl0_ff[`CAD_CTL_OVFIE];
        irq_src[`CAD_ST_SECOND_BLOCK_OVERFLOW_FLAG] = status_ff[`CAD_ST_SECOND_BLOCK_OVERFLOW_FLAG] &
                                ctrl1_ff[`CAD_CTL_OVFIE];
        // three module flags sit on each side of an overflow bit
        for (k = 0; k < 3; k = k + 1)
        begin
            irq_src[k]   = status_ff[k] &
                           mode_flat[k*8 + `CAD_MD_IRQE];
            irq_src[k+4] = status_ff[k+4] &
                           mode_flat[(k+3)*8 + `CAD_MD_IRQE];
        end
    end

    always @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            IRQ <= 1'b0;
        else
            IRQ <= |irq_src;
    end

    // ----------------------------------------------------------------
    // register read
    // ----------------------------------------------------------------
    always @*
    begin
        nxt_rdata = 8'h00;
        // reserved control bits read zero, masked when written
        case (SFR_ADDR)
            `CAD_ADDR_CTRL0:  nxt_rdata = ctrl0_ff;
            `CAD_ADDR_CTRL1:  nxt_rdata = ctrl1_ff;
            `CAD_ADDR_STATUS: nxt_rdata = status_ff;
            `CAD_ADDR_MODE0:  nxt_rdata = mode_flat[7:0];
            `CAD_ADDR_MODE1:  nxt_rdata = mode_flat[15:8];
            `CAD_ADDR_MODE2:  nxt_rdata = mode_flat[23:16];
            `CAD_ADDR_MODE3:  nxt_rdata = mode_flat[31:24];
            `CAD_ADDR_MODE4:  nxt_rdata = mode_flat[39:32];
            `CAD_ADDR_MODE5:  nxt_rdata = mode_flat[47:40];
            default:          nxt_rdata = 8'h00;
        endcase
    end

    always @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            SFR_RDATA <= 8'h00;
        else if (SFR_RD)
            SFR_RDATA <= nxt_rdata;
    end

endmodule

// ==== cad_defines.vh ====
`ifndef CAD_DEFINES_VH
`define CAD_DEFINES_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define CAD_ADDR_CTRL0   8'ha4
`define CAD_ADDR_STATUS  8'ha5
`define CAD_ADDR_CTRL1   8'hbc
`define CAD_ADDR_MODE0   8'hc0
`define CAD_ADDR_MODE1   8'hc1
`define CAD_ADDR_MODE2   8'hc2
`define CAD_ADDR_MODE3   8'hc3
`define CAD_ADDR_MODE4   8'hc4
`define CAD_ADDR_MODE5   8'hc5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CAD_RST_CTRL     8'h00
`define CAD_RST_STATUS   8'h00
`define CAD_RST_MODE     8'h00

// ----------------------------------------------------------------
// block control fields
// ----------------------------------------------------------------
`define CAD_CTL_ALL      7
`define CAD_CTL_RUN      6
`define CAD_CTL_OVFIE    5
`define CAD_CTL_IDLE     4
`define CAD_CTL_TENBIT   2
`define CAD_CTL_CLK_HI   1
`define CAD_CTL_CLK_LO   0
`define CAD_CTL1_MASK    8'h77
`define CAD_CTL0_MASK    8'hf7

// ----------------------------------------------------------------
// clock select codes
// ----------------------------------------------------------------
`define CAD_CLK_PRESC    2'h0
`define CAD_CLK_T0OVF    2'h1
`define CAD_CLK_EXT      2'h2

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define CAD_ST_SECOND_BLOCK_OVERFLOW_FLAG      7
`define CAD_ST_FIRST_BLOCK_OVERFLOW_FLAG      3

// ----------------------------------------------------------------
// module function select fields
// ----------------------------------------------------------------
`define CAD_MD_IRQE      7
`define CAD_MD_COMP      6
`define CAD_MD_CAPR      5
`define CAD_MD_CAPF      4
`define CAD_MD_MATCH     3
`define CAD_MD_TOGGLE    2
`define CAD_MD_PWM_HI    1
`define CAD_MD_PWM_LO    0

// ----------------------------------------------------------------
// pwm select codes
// ----------------------------------------------------------------
`define CAD_PWM_OFF      2'h0
`define CAD_PWM_FIX8     2'h1
`define CAD_PWM_PRG8     2'h2
`define CAD_PWM_WIDE     2'h3

`endif

// ==== cad_pin_model.sv ====
`timescale 1ns/1ps
module cad_pin_model
(
    // levels the block drives
    input  wire [5:0] pin_out,
    input  wire [5:0] pin_oe,
    // level the block sees
    output wire [5:0] pin_in
);
    reg [5:0] ext_lvl;

    initial ext_lvl = 6'h00;
    // a driven pin reads back its own level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);

    // outside source moves a capture pin
    task set_ext(input integer n, input logic v);
        ext_lvl[n] = v;
    endtask
endmodule

// ==== cad_ctrl_chk.sv ====
`timescale 1ns/1ps
module cad_ctrl_chk
#(
    parameter NMOD = 6
)
(
    // clock and reset
    input wire              CLK,
    input wire              NRST,
    // register port and cpu
    input wire [7:0]        SFR_ADDR,
    input wire [7:0]        SFR_WDATA,
    input wire              SFR_WR,
    input wire              CPU_IDLE,
    // counters, modules, pins
    input wire [1:0]        CNT_OVF,
    input wire [1:0]        CNT_RUN,
    input wire [3:0]        CNT_CLK_SEL,
    input wire [1:0]        CNT_TEN_BIT,
    input wire [NMOD-1:0]   CMP_MATCH,
    input wire [NMOD*2-1:0] PWM_SEL,
    input wire [NMOD-1:0]   CAPTURE,
    input wire [NMOD-1:0]   MODULE_PIN_IN,
    input wire [NMOD-1:0]   MODULE_PIN_OUT,
    input wire [NMOD-1:0]   MODULE_PIN_OE,
    input wire              IRQ
);
    reg  [7:0]        c0_ff;
    reg  [7:0]        c1_ff;
    reg  [NMOD*8-1:0] md_ff;
    reg  [1:0]        qc_ff;
    reg               idle_ff;
    wire [NMOD*2-1:0] psel;
    wire [NMOD-1:0]   oex;
    wire [NMOD-1:0]   mie;
    genvar            g;

    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);

    // ------------------------------------------------------------
    // shadow of the written registers; qc counts quiet cycles
    // ------------------------------------------------------------
    generate
        for (g = 0; g < NMOD; g = g + 1)
        begin : g_md
            assign psel[2*g +: 2] = md_ff[8*g +: 2];
            assign oex[g] = |md_ff[8*g +: 3];
            assign mie[g] = md_ff[8*g+7];
        end
    endgenerate

    always @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            c0_ff <= 8'h00;
            c1_ff <= 8'h00;
            md_ff <= {NMOD*8{1'b0}};
            qc_ff <= 2'h0;
            idle_ff <= 1'b0;
        end
        else
        begin
            if (SFR_WR && SFR_ADDR == 8'ha4)
                c0_ff <= SFR_WDATA;
            if (SFR_WR && SFR_ADDR == 8'hbc)
                c1_ff <= SFR_WDATA;
            if (SFR_WR && SFR_ADDR[7:3] == 5'h18 && SFR_ADDR[2:0] < 3'h6)
                md_ff[SFR_ADDR[2:0]*8 +: 8] <= SFR_WDATA;
            idle_ff <= CPU_IDLE;
            if (SFR_WR || CPU_IDLE != idle_ff)
                qc_ff <= 2'h0;
            else if (qc_ff != 2'h3)
                qc_ff <= qc_ff + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_run_gate: assert property (
        qc_ff == 2'h3 |-> CNT_RUN[1] ==
        ((c1_ff[6] | c0_ff[7]) & !(c1_ff[4] & $past(CPU_IDLE))))
        else $error("run output wrong");
    a_clk_sel: assert property (
        qc_ff == 2'h3 |-> CNT_CLK_SEL[3:2] == c1_ff[1:0])
        else $error("clock select wrong");
    a_ten_bit: assert property (
        qc_ff == 2'h3 |-> CNT_TEN_BIT == {c1_ff[2], c0_ff[2]})
        else $error("width select wrong");
    a_ovf_irq: assert property (
        CNT_OVF[1] && c1_ff[5] && !SFR_WR ##1 !SFR_WR |=> IRQ)
        else $error("overflow irq missing");
    a_irq_masked: assert property (
        $past({c1_ff[5], c0_ff[5], mie}) == 0 |-> !IRQ)
        else $error("irq without enable");
    a_pwm_sel: assert property (
        qc_ff == 2'h3 |-> PWM_SEL == psel)
        else $error("pwm code wrong");
    a_pin_oe: assert property (
        qc_ff == 2'h3 |-> MODULE_PIN_OE == oex)
        else $error("pin enable wrong");
    a_toggle_pin: assert property (
        CMP_MATCH[0] && !$past(CMP_MATCH[0]) && qc_ff == 2'h3 && !SFR_WR
        && md_ff[6] && md_ff[2:0] == 3'h4 |->
        ##2 MODULE_PIN_OUT[0] != $past(MODULE_PIN_OUT[0], 2))
        else $error("pin did not toggle");
    a_cap_rise: assert property (
        $rose(MODULE_PIN_IN[3]) && md_ff[29] && qc_ff == 2'h3 |->
        ##[2:5] CAPTURE[3])
        else $error("capture missing");
    a_cap_once: assert property (
        CAPTURE[3] && !md_ff[28] |=> !CAPTURE[3])
        else $error("capture repeated");
endmodule

bind cad_counter_array_ctrl cad_ctrl_chk #(.NMOD(NMOD)) cad_ctrl_chk_i (
    .CLK(CLK), .NRST(NRST), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
    .SFR_WR(SFR_WR), .CPU_IDLE(CPU_IDLE), .CNT_OVF(CNT_OVF),
    .CNT_RUN(CNT_RUN), .CNT_CLK_SEL(CNT_CLK_SEL),
    .CNT_TEN_BIT(CNT_TEN_BIT), .CMP_MATCH(CMP_MATCH), .PWM_SEL(PWM_SEL),
    .CAPTURE(CAPTURE), .MODULE_PIN_IN(MODULE_PIN_IN),
    .MODULE_PIN_OUT(MODULE_PIN_OUT), .MODULE_PIN_OE(MODULE_PIN_OE),
    .IRQ(IRQ));

// ==== cad_counter_array_ctrl_test.sv ====
`timescale 1ns/1ps
module cad_counter_array_ctrl_test;
    reg         clk, nrst, sfr_wr, sfr_rd, cpu_idle;
    reg  [7:0]  sfr_addr, sfr_wdata;
    reg  [1:0]  cnt_ovf, lo_ovf;
    reg  [15:0] cnt_lo;
    reg  [5:0]  cmp_match, wide_lvl;
    reg  [47:0] duty_hi;
    wire [7:0]  rdata;
    wire [1:0]  cnt_run, ten_bit;
    wire [3:0]  clk_sel;
    wire [11:0] pwm_sel;
    wire [5:0]  capture, pin_in, pin_out, pin_oe;
    wire        irq;
    integer     err_count, compares, caps, i, j;
    logic       p;

    cad_counter_array_ctrl #(.NMOD(6)) cad_counter_array_ctrl_i (
        .CLK(clk), .NRST(nrst), .SFR_ADDR(sfr_addr), .SFR_WDATA(sfr_wdata),
        .SFR_WR(sfr_wr), .SFR_RD(sfr_rd), .SFR_RDATA(rdata),
        .CPU_IDLE(cpu_idle), .CNT_OVF(cnt_ovf), .CNT_LO_OVF(lo_ovf),
        .CNT_LO(cnt_lo), .CNT_RUN(cnt_run), .CNT_CLK_SEL(clk_sel),
        .CNT_TEN_BIT(ten_bit), .CMP_MATCH(cmp_match), .DUTY_HI(duty_hi),
        .PWM_WIDE_LVL(wide_lvl), .PWM_SEL(pwm_sel), .CAPTURE(capture),
        .MODULE_PIN_IN(pin_in), .MODULE_PIN_OUT(pin_out),
        .MODULE_PIN_OE(pin_oe), .IRQ(irq));
    cad_pin_model cad_pin_model_i (
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        compares = compares + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("CHECK FAILED %0s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wt(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask
    task rd(input [7:0] a, input [7:0] exp, input string nm);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        chk(nm, rdata, exp);
    endtask
    task pulse(input [1:0] ov, input [5:0] m, input [1:0] lo);
        @(negedge clk);
        cnt_ovf = ov;
        cmp_match = m;
        lo_ovf = lo;
        @(negedge clk);
        cnt_ovf = 2'h0;
        cmp_match = 6'h00;
        lo_ovf = 2'h0;
    endtask
    task final_report;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial clk = 1'b0;
    always #12.5 clk = ~clk;
    always @(posedge clk)
        if (capture[3] === 1'b1)
            caps = caps + 1;
    initial
    begin
        #500000;
        err_count = err_count + 1;
        final_report;
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        {nrst, sfr_wr, sfr_rd, cpu_idle, cnt_ovf, lo_ovf} = 8'h00;
        {sfr_addr, sfr_wdata, cnt_lo, cmp_match, duty_hi} = 86'h0;
        wide_lvl = 6'h3f;
        {err_count, compares, caps} = 96'h0;
        wt(4);
        nrst = 1'b1;
        chk("irq", irq, 1'b0); // idle
        rd(8'ha5, 8'h00, "status"); // reset
        rd(8'hbc, 8'h00, "ctrl1"); // reset
        for (i = 0; i < 6; i = i + 1)
            rd(8'hc0 + i[7:0], 8'h00, "mode"); // reset
        wr(8'ha6, 8'hff);
        rd(8'ha6, 8'h00, "unmapped");
        wr(8'hbc, 8'hff);
        rd(8'hbc, 8'h77, "ctrl1"); // masked
        for (i = 0; i < 3; i = i + 1)
        begin
            wr(8'hbc, 8'h54 | i[7:0]);
            wt(3);
            chk("clk", clk_sel[3:2], i[1:0]); // code
            chk("ten", ten_bit, 2'h2); // width
            chk("run", cnt_run, 2'h2); // run
        end
        cpu_idle = 1'b1;
        wt(3);
        chk("run", cnt_run, 2'h0); // halted
        wr(8'hbc, 8'h40);
        wt(3);
        chk("run", cnt_run, 2'h2); // idle kept
        cpu_idle = 1'b0;
        wr(8'hbc, 8'h20);
        wt(3);
        chk("run", cnt_run, 2'h0); // stopped
        wr(8'ha4, 8'h80);
        wt(3);
        chk("run", cnt_run, 2'h3); // common start
        wr(8'ha4, 8'h00);
        $display("test control done");
        pulse(2'h2, 6'h00, 2'h0);
        wt(2);
        chk("irq", irq, 1'b1); // overflow
        pulse(2'h1, 6'h00, 2'h0);
        wt(3);
        rd(8'ha5, 8'h88, "status"); // both held
        wr(8'ha5, 8'h08);
        wt(2);
        rd(8'ha5, 8'h08, "status"); // cleared
        chk("irq", irq, 1'b0); // masked
        wr(8'ha5, 8'h80);
        wt(2);
        chk("irq", irq, 1'b1); // sw set
        wr(8'ha5, 8'h00);
        wr(8'hbc, 8'h00);
        $display("test overflow done");
        for (i = 0; i < 6; i = i + 1)
        begin
            wr(8'hc0 + i[7:0], 8'hc8);
            pulse(2'h0, 6'h01 << i, 2'h0);
            wt(2);
            chk("irq", irq, 1'b1); // merged
            rd(8'ha5, 8'h01 << (i < 3 ? i : i + 1), "flag");
            wr(8'ha5, 8'h00);
            wr(8'hc0 + i[7:0], 8'h88);
            pulse(2'h0, 6'h01 << i, 2'h0);
            wt(2);
            rd(8'ha5, 8'h00, "flag"); // comparator off
            wr(8'hc0 + i[7:0], 8'h48);
            pulse(2'h0, 6'h01 << i, 2'h0);
            wt(2);
            chk("irq", irq, 1'b0); // no enable
            wr(8'ha5, 8'h00);
            wr(8'hc0 + i[7:0], 8'h00);
        end
        $display("test events done");
        wr(8'hc0, 8'h4c);
        wt(3);
        chk("oe", pin_oe[0], 1'b1); // driven
        p = pin_out[0];
        for (i = 0; i < 2; i = i + 1)
        begin
            pulse(2'h0, 6'h01, 2'h0);
            wt(3);
            chk("pin", pin_out[0], p ^ !i[0]); // toggled
        end
        wr(8'ha5, 8'h00);
        for (i = 1; i < 4; i = i + 1)
        begin
            wr(8'ha4, i == 3 ? 8'h04 : 8'h00); // width paired
            for (j = 0; j < 3; j = j + 1)
                wr(8'hc0 + j[7:0], 8'h40 | i[7:0]); // alike
            wt(3);
            chk("pwm", pwm_sel[5:0], {3{i[1:0]}}); // code
            chk("oe", pin_oe[2:0], 3'h7); // pwm pin
        end
        chk("pin", pin_out[1], 1'b1); // wide level
        for (j = 0; j < 3; j = j + 1)
            wr(8'hc0 + j[7:0], 8'h00);
        wr(8'ha4, 8'h00);
        wr(8'hc2, 8'h41);
        duty_hi[23:16] = 8'h80;
        pulse(2'h0, 6'h00, 2'h1);
        cnt_lo[7:0] = 8'h80;
        wt(3);
        chk("pwm pin", pin_out[2], 1'b1); // equal duty
        cnt_lo[7:0] = 8'h7f;
        duty_hi[23:16] = 8'h10;
        wt(3);
        chk("pwm pin", pin_out[2], 1'b0); // staged
        pulse(2'h0, 6'h00, 2'h1);
        wt(3);
        chk("pwm pin", pin_out[2], 1'b1); // reloaded
        wr(8'hc2, 8'h00);
        $display("test pwm done");
        for (i = 0; i < 2; i = i + 1)
        begin
            wr(8'hc3, i == 0 ? 8'ha0 : 8'hb0);
            wt(3);
            cad_pin_model_i.set_ext(3, 1'b1);
            wt(6);
            rd(8'ha5, 8'h10, "capture"); // rising
            wr(8'ha5, 8'h00);
            cad_pin_model_i.set_ext(3, 1'b0);
            wt(6);
            rd(8'ha5, i == 0 ? 8'h00 : 8'h10, "capture");
            wr(8'ha5, 8'h00);
        end
        chk("captures", caps, 3); // one per enabled edge
        $display("test capture done");
        final_report;
    end
endmodule
